// ===== src/reclocker_int_lock_monitor.sv
/*
  Interrupt status, enables, boost readback and eye-lock monitor registers.
  Assumes a serial management front end that presents byte reads and writes
  as one-cycle strobes on clk; analog status levels arrive asynchronously.
*/
`timescale 1ns/1ps
`include "lock_monitor_params.svh"

module reclocker_int_lock_monitor
  import lock_monitor_pkg::*;
#(
  parameter int INTERVAL_CYCLES = `EYE_INTERVAL_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic [7:0] active_boost_value,
  input  wire logic       selected_carrier,
  input  wire logic       primary_carrier,
  input  wire logic       cdr_locked,
  input  wire logic [7:0] horiz_opening,
  input  wire logic [7:0] vert_opening,
  output logic            eye_locked,
  output logic            irq
);

  // ----------------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------------
  logic sel_car_lvl;
  logic pri_lvl;
  logic pri_rise;
  logic pri_fall;
  logic lock_lvl;
  logic lock_rise;
  logic lock_fall;
  logic [7:0] boost_m_q;
  logic [7:0] boost_s_q;
  logic [7:0] heo_m_q;
  logic [7:0] heo_s_q;
  logic [7:0] veo_m_q;
  logic [7:0] veo_s_q;

  edge_sync u_sel_sync (
    .clk      (clk),
    .rstn     (rstn),
    .async_in (selected_carrier),
    .level    (sel_car_lvl),
    .rise     (),
    .fall     ()
  );

  edge_sync u_pri_sync (
    .clk      (clk),
    .rstn     (rstn),
    .async_in (primary_carrier),
    .level    (pri_lvl),
    .rise     (pri_rise),
    .fall     (pri_fall)
  );

  edge_sync u_lock_sync (
    .clk      (clk),
    .rstn     (rstn),
    .async_in (cdr_locked),
    .level    (lock_lvl),
    .rise     (lock_rise),
    .fall     (lock_fall)
  );

  // ----------------------------------------------------------------------
  // Analog level samplers
  // ----------------------------------------------------------------------
  // Multi-bit analog values are assumed slow-moving; a torn sample
  // settles on the next cycle.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      boost_m_q <= 8'h00;
      boost_s_q <= 8'h00;
    end else begin
      boost_m_q <= active_boost_value;
      boost_s_q <= boost_m_q;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      heo_m_q <= 8'h00;
      heo_s_q <= 8'h00;
    end else begin
      heo_m_q <= horiz_opening;
      heo_s_q <= heo_m_q;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      veo_m_q <= 8'h00;
      veo_s_q <= 8'h00;
    end else begin
      veo_m_q <= vert_opening;
      veo_s_q <= veo_m_q;
    end
  end

  // ----------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------
  reg_byte_t status_q;
  reg_byte_t status_d;
  reg_byte_t enable_q;
  reg_byte_t interval_q;
  reg_byte_t thresh_q;

  // Exact match only: a partial decode would alias the reserved neighbours
  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] target);
    return (addr == target);
  endfunction : addr_is

  wire sel_boost    = addr_is(reg_addr, `ADDR_ACTIVE_BOOST);
  wire sel_status   = addr_is(reg_addr, `ADDR_INT_STATUS);
  wire sel_enable   = addr_is(reg_addr, `ADDR_INT_ENABLE);
  wire sel_interval = addr_is(reg_addr, `ADDR_EYE_INTERVAL);
  wire sel_thresh   = addr_is(reg_addr, `ADDR_EYE_THRESHOLD);
  wire status_read  = reg_rd && sel_status;
  wire enable_wr    = reg_wr && sel_enable;
  wire interval_wr  = reg_wr && sel_interval;
  wire thresh_wr    = reg_wr && sel_thresh;

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)          enable_q <= `RST_INT_ENABLE;
    else if (enable_wr) enable_q <= reg_wdata & `ENABLE_DEFINED_MASK;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)            interval_q <= `RST_EYE_INTERVAL;
    else if (interval_wr) interval_q <= {4'h0, reg_wdata[3:0]};
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)          thresh_q <= `RST_EYE_THRESHOLD;
    else if (thresh_wr) thresh_q <= reg_wdata;
  end

  // ----------------------------------------------------------------------
  // Eye-lock monitor
  // ----------------------------------------------------------------------
  logic check_tick;
  logic eye_hit_q;
  eye_state_t eye_state_q;
  eye_state_t eye_state_d;

  eye_check_timer #(
    .INTERVAL_CYCLES (INTERVAL_CYCLES)
  ) u_timer (
    .clk            (clk),
    .rstn           (rstn),
    .enable         (lock_lvl),
    .interval_count (interval_q[3:0]),
    .check_tick     (check_tick)
  );

  wire [7:0] heo_limit = {2'b00, thresh_q[3:0], 2'b00};
  wire [7:0] veo_limit = {2'b00, thresh_q[7:4], 2'b00};
  wire       eye_ok    = (heo_s_q >= heo_limit) && (veo_s_q >= veo_limit);
  wire       eye_event = (eye_state_q == EYE_CHECK) && eye_ok && !eye_locked;

  always_comb begin
    eye_state_d = eye_state_q;
    case (eye_state_q)
      EYE_IDLE: begin
        if (lock_lvl)
          eye_state_d = EYE_WAIT;
      end
      EYE_WAIT: begin
        if (!lock_lvl)
          eye_state_d = EYE_IDLE;
        else if (check_tick)
          eye_state_d = EYE_CHECK;
      end
      EYE_CHECK: begin
        if (lock_lvl)
          eye_state_d = EYE_WAIT;
        else
          eye_state_d = EYE_IDLE;
      end
      default: begin
        eye_state_d = EYE_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Eye-lock registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) eye_state_q <= EYE_IDLE;
    else       eye_state_q <= eye_state_d;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) eye_hit_q <= 1'b0;
    else       eye_hit_q <= eye_event;
  end

  // Losing the recovery loop drops eye lock at once; it is only
  // declared again by the next passing check.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      eye_locked <= 1'b0;
    else if (!lock_lvl)
      eye_locked <= 1'b0;
    else if (eye_state_q == EYE_CHECK)
      eye_locked <= eye_ok;
  end

  // ----------------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------------
  // Events set regardless of enables so software can poll; the enables
  // only gate the interrupt line.
  wire ev_lock_gained  = lock_rise;
  wire ev_signal_found = pri_rise;
  wire ev_eye_reached  = eye_hit_q;
  wire ev_lock_lost    = lock_fall;
  wire ev_signal_lost  = pri_fall;

  wire [7:0] set_vec = {1'b0,
                        ev_lock_gained,
                        ev_signal_found,
                        1'b0,
                        ev_eye_reached,
                        ev_lock_lost,
                        ev_signal_lost,
                        1'b0};

  // ----------------------------------------------------------------------
  // Status register
  // ----------------------------------------------------------------------
  // A read clears every defined bit, carrier bit included; an event in the
  // same cycle is merged after the clear so it is never lost.
  always_comb begin
    status_d = status_q;
    if (status_read)
      status_d = 8'h00;
    status_d = status_d | set_vec;
    status_d[`BIT_CARRIER_PRESENT] = sel_car_lvl && !status_read;
    status_d = status_d & `STATUS_DEFINED_MASK;
  end

  // Carrier bit follows the live level, so a read clears it only until the
  // next cycle while carrier remains present.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) status_q <= `RST_INT_STATUS;
    else       status_q <= status_d;
  end

  // ----------------------------------------------------------------------
  // Interrupt line and read data
  // ----------------------------------------------------------------------
  wire [7:0] gated = status_d & enable_q;
  wire       irq_d = |gated;

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // Unmapped addresses select nothing and so read as zero
  wire [7:0] boost_rd    = sel_boost    ? boost_s_q  : 8'h00;
  wire [7:0] status_rd   = sel_status   ? status_q   : 8'h00;
  wire [7:0] enable_rd   = sel_enable   ? enable_q   : 8'h00;
  wire [7:0] interval_rd = sel_interval ? interval_q : 8'h00;
  wire [7:0] thresh_rd   = sel_thresh   ? thresh_q   : 8'h00;
  wire [7:0] rd_mux      = boost_rd | status_rd | enable_rd | interval_rd | thresh_rd;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) irq <= 1'b0;
    else       irq <= irq_d;
  end

  // Read data holds between reads so a slow host may sample it late
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)       reg_rdata <= 8'h00;
    else if (reg_rd) reg_rdata <= rd_mux;
  end

endmodule : reclocker_int_lock_monitor

// ===== src/lock_monitor_params.svh
/*
  Register offsets, field positions, reset values and timing counts for the
  interrupt and eye-lock monitor register group.
  Assumes a 20 MHz clock and 8-bit register access by address.
*/
`ifndef LOCK_MONITOR_PARAMS_SVH
`define LOCK_MONITOR_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ADDR_ACTIVE_BOOST     8'h52
`define ADDR_INT_STATUS       8'h54
`define ADDR_INT_ENABLE       8'h56
`define ADDR_EYE_INTERVAL     8'h69
`define ADDR_EYE_THRESHOLD    8'h6A

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_CARRIER_PRESENT   7
`define BIT_LOCK_GAINED       6
`define BIT_SIGNAL_FOUND      5
`define BIT_EYE_THRESHOLD     3
`define BIT_LOCK_LOST         2
`define BIT_SIGNAL_LOST       1
`define STATUS_DEFINED_MASK   8'hEE
`define ENABLE_DEFINED_MASK   8'h6E

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_INT_STATUS        8'h00
`define RST_INT_ENABLE        8'h00
`define RST_EYE_INTERVAL      8'h0A
`define RST_EYE_THRESHOLD     8'h44

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_FREQ_HZ           20000000
`define EYE_INTERVAL_US       6500
`define EYE_INTERVAL_CYCLES   ((`CLK_FREQ_HZ / 1000000) * `EYE_INTERVAL_US)

`endif

// ===== src/lock_monitor_pkg.sv
/*
  Types shared by the monitor block.
  Assumes the params header for all numbers.
*/
package lock_monitor_pkg;

  typedef logic [7:0] reg_byte_t;

  typedef enum logic [1:0] {
    EYE_IDLE,
    EYE_WAIT,
    EYE_CHECK
  } eye_state_t;

endpackage : lock_monitor_pkg

// ===== src/edge_sync.sv
/*
  Two-flop synchroniser with rise and fall pulses.
  Assumes an asynchronous level from outside the clock domain.
*/
`timescale 1ns/1ps
module edge_sync (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic async_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise  = sync_q & ~prev_q;
  assign fall  = ~sync_q & prev_q;

endmodule : edge_sync

// ===== src/eye_check_timer.sv
/*
  Eye-opening check timer: one tick every N intervals.
  Assumes N arrives from a register on the same clock; N of zero stops checks.
*/
`timescale 1ns/1ps
`include "lock_monitor_params.svh"
module eye_check_timer #(
  parameter int INTERVAL_CYCLES = `EYE_INTERVAL_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       enable,
  input  wire logic [3:0] interval_count,
  output logic            check_tick
);

  logic [31:0] cyc_q;
  logic [3:0]  n_q;
  wire         interval_end = (cyc_q == 32'(INTERVAL_CYCLES - 1));
  wire         period_end   = interval_end && (n_q + 4'h1 >= interval_count);

  // ----------------------------------------------------------------------
  // Interval counting
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cyc_q      <= 32'h0;
      n_q        <= 4'h0;
      check_tick <= 1'b0;
    end else if (!enable || interval_count == 4'h0) begin
      cyc_q      <= 32'h0;
      n_q        <= 4'h0;
      check_tick <= 1'b0;
    end else begin
      cyc_q      <= interval_end ? 32'h0 : cyc_q + 32'h1;
      n_q        <= period_end ? 4'h0 : (interval_end ? n_q + 4'h1 : n_q);
      check_tick <= period_end;
    end
  end

endmodule : eye_check_timer

// ===== bench/lock_check_monitor.sv
/*
  Port assertions for the interrupt and eye-lock monitor block.
  Assumes a bind from the bench top and one clock with async active-low reset.
*/
`timescale 1ns/1ps
module lock_check_monitor (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] active_boost_value,
  input wire logic       selected_carrier,
  input wire logic       primary_carrier,
  input wire logic       cdr_locked,
  input wire logic [7:0] horiz_opening,
  input wire logic [7:0] vert_opening,
  input wire logic       eye_locked,
  input wire logic       irq
);
  // --------------------------------------------------------------------
  // Shadow copies of enable and threshold writes
  // --------------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [7:0] en_q;
  logic [7:0] th_q;
  wire        st_rd = reg_rd && reg_addr == 8'h54;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      en_q <= 8'h00;
      th_q <= 8'h44;
    end else if (reg_wr) begin
      if (reg_addr == 8'h56) en_q <= reg_wdata;
      if (reg_addr == 8'h6A) th_q <= reg_wdata;
    end
  end
  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  property p_boost_read;
    $stable(active_boost_value)[*4] ##0 reg_rd && reg_addr == 8'h52 |=> reg_rdata == $past(active_boost_value);
  endproperty
  a_boost_read: assert property (p_boost_read) else $error("boost readback wrong");
  property p_carrier_bit;
    (!st_rd && $stable(selected_carrier))[*4] ##1 st_rd |=> reg_rdata[7] == $past(selected_carrier, 4);
  endproperty
  a_carrier_bit: assert property (p_carrier_bit) else $error("carrier bit wrong");
  // Inputs held still so no fresh lock or signal event can land between the two reads
  property p_read_clear;
    ($stable(cdr_locked) && $stable(primary_carrier))[*5] ##0 st_rd ##1 st_rd |=> (reg_rdata & 8'hF7) == 8'h00;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("status not cleared");
  property p_enable_rw;
    reg_wr && reg_addr == 8'h56 ##2 reg_rd && reg_addr == 8'h56 |=> reg_rdata == ($past(reg_wdata, 3) & 8'h6E);
  endproperty
  a_enable_rw: assert property (p_enable_rw) else $error("enable readback wrong");
  property p_thresh_rw;
    reg_wr && reg_addr == 8'h6A ##2 reg_rd && reg_addr == 8'h6A |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_thresh_rw: assert property (p_thresh_rw) else $error("threshold readback wrong");
  property p_irq_off;
    ((en_q & 8'h6E) == 8'h00)[*2] |-> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq with no enable");
  property p_eye_cdr;
    (!cdr_locked)[*6] |-> !eye_locked;
  endproperty
  a_eye_cdr: assert property (p_eye_cdr) else $error("eye lock without cdr");
  property p_eye_rose;
    $rose(eye_locked) |-> $past(horiz_opening, 3) >= {2'b00, th_q[3:0], 2'b00}
                          && $past(vert_opening, 3) >= {2'b00, th_q[7:4], 2'b00};
  endproperty
  a_eye_rose: assert property (p_eye_rose) else $error("eye lock below threshold");
endmodule : lock_check_monitor

// ===== bench/host_bus_model.sv
/*
  Host side of the byte register strobes.
  Assumes the shared clock; the bench top calls xfer hierarchically.
*/
`timescale 1ns/1ps
module host_bus_model (
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  // --------------------------------------------------------------------
  // Byte transfers
  // --------------------------------------------------------------------
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  // Strobe held n edges gives back-to-back requests; idle bus shows inverted values
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, input int n, output logic [7:0] q);
    @(posedge clk);
    reg_wr    <= wr;
    reg_rd    <= !wr;
    reg_addr  <= a;
    reg_wdata <= d;
    repeat (n) @(posedge clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
    #1 q = reg_rdata;
  endtask : xfer
endmodule : host_bus_model

// ===== bench/reclocker_int_lock_monitor_tb.sv
/*
  Self-checking bench: status model against the monitor block.
  Assumes a shortened eye interval and the host strobe model.
*/
`timescale 1ns/1ps
module reclocker_int_lock_monitor_tb;
  import lock_monitor_pkg::*;
  // --------------------------------------------------------------------
  // Bench
  // --------------------------------------------------------------------
  localparam int IC = 20;
  logic      clk, rstn, reg_wr, reg_rd, selected_carrier, primary_carrier, cdr_locked, eye_locked, irq;
  reg_byte_t reg_addr, reg_wdata, reg_rdata, active_boost_value, horiz_opening, vert_opening, q, en, th;
  int        failures = 0, checked = 0, seed = 25, st = 0, r;
  reclocker_int_lock_monitor #(.INTERVAL_CYCLES(IC)) dut_u (.clk(clk), .rstn(rstn), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .active_boost_value(active_boost_value), .selected_carrier(selected_carrier),
    .primary_carrier(primary_carrier), .cdr_locked(cdr_locked), .horiz_opening(horiz_opening),
    .vert_opening(vert_opening), .eye_locked(eye_locked), .irq(irq));
  host_bus_model host_u (.clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic rd(input logic [7:0] a, input int n, input logic [7:0] exp);
    host_u.xfer(1'b0, a, 8'h00, n, q);
    cmp(q, exp);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.xfer(1'b1, a, d, 1, q);
  endtask : wr
  // A second back-to-back read sees bit 7 still in its one-cycle clear
  task automatic rdst(input int n);
    rd(8'h54, n, n > 1 ? 8'h00 : 8'(st & 8'h6E) | {selected_carrier, 7'h00});
    st = 0;
  endtask : rdst
  task automatic drive(input logic pc, input logic sc, input logic cl);
    if (pc !== primary_carrier) st |= pc ? 8'h20 : 8'h02;
    if (cl !== cdr_locked) st |= cl ? 8'h40 : 8'h04;
    @(posedge clk);
    primary_carrier  <= pc;
    selected_carrier <= sc;
    cdr_locked       <= cl;
    repeat (6) @(posedge clk);
  endtask : drive
  task automatic tally_and_finish();
    if (failures == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
  initial begin
    {rstn, selected_carrier, primary_carrier, cdr_locked} = 4'h0;
    {active_boost_value, horiz_opening, vert_opening} = 24'h000000;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rd(8'h56, 1, 8'h00);
    rd(8'h69, 1, 8'h0A);
    rd(8'h6A, 1, 8'h44);
    rdst(1);
    wr(8'h53, 8'hFF);
    wr(8'h52, 8'hFF);
    rd(8'h53, 1, 8'h00);
    rd(8'h52, 1, 8'h00);
    repeat (3) begin
      @(posedge clk) active_boost_value <= 8'($random(seed));
      repeat (4) @(posedge clk);
      rd(8'h52, 1, active_boost_value);
    end
    wr(8'h69, 8'hF1);
    rd(8'h69, 1, 8'h01);
    for (int i = 0; i < 8; i++) begin
      r  = $random(seed);
      en = 8'(r);
      wr(8'h56, en);
      rd(8'h56, 1, en & 8'h6E);
      drive(r[8], r[9], r[10]);
      cmp({7'h00, irq}, {7'h00, |(st[7:0] & en & 8'h6E)});
      rdst(1 + r[11]);
    end
    th = 8'($random(seed)) | 8'h11;
    wr(8'h6A, th);
    rd(8'h6A, 1, th);
    wr(8'h56, 8'h08);
    en = 8'h08;
    for (int k = 0; k < 2; k++) begin
      drive(1'b1, 1'b1, 1'b0);
      rdst(1);
      @(posedge clk);
      horiz_opening <= 8'({th[3:0], 2'b00} - k);
      vert_opening  <= {2'b00, th[7:4], 2'b00};
      drive(1'b1, 1'b1, 1'b1);
      repeat (3 * IC) @(posedge clk);
      if (k == 0) st |= 8'h08;
      cmp({7'h00, eye_locked}, {7'h00, k == 0});
      cmp({7'h00, irq}, {7'h00, |(st[7:0] & en & 8'h6E)});
      rdst(1);
    end
    tally_and_finish();
  end
endmodule : reclocker_int_lock_monitor_tb
bind reclocker_int_lock_monitor lock_check_monitor chk_u (.clk(clk), .rstn(rstn), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .active_boost_value(active_boost_value), .selected_carrier(selected_carrier),
  .primary_carrier(primary_carrier), .cdr_locked(cdr_locked), .horiz_opening(horiz_opening),
  .vert_opening(vert_opening), .eye_locked(eye_locked), .irq(irq));
